//--- rtl/bsc_pkg.sv
// shared constants and types of the synchronous burst sram control block
// assumes one clock domain, clk_sys, with a synchronous active-high reset
package bsc_pkg;

    // ----------------------------------------------------------------
    // geometry
    // ----------------------------------------------------------------
    localparam int BSC_LANES_WIDE = 4;       // lanes a..d
    localparam int BSC_LANES_NARROW = 2;     // lanes a..b only
    localparam int BSC_LANE_W = 9;           // eight data bits plus parity
    localparam int BSC_ADDR_W = 22;          // word address of the wide array
    localparam int BSC_OFS_W = 2;            // burst offset bits

    // ----------------------------------------------------------------
    // reset values and counts
    // ----------------------------------------------------------------
    localparam logic [1:0] BSC_OFS_RESET = 2'h0;
    localparam logic [1:0] BSC_STEP_ONE = 2'h1;
    localparam int BSC_SYNC_STAGES = 3;      // pin synchroniser depth

    // ----------------------------------------------------------------
    // static mode pins, in pin polarity
    // ----------------------------------------------------------------
    typedef struct packed {
        logic burst_order_select_n;   // low = linear, high = interleaved
        logic flow_through_select_n;  // low = flow-through, high = pipeline
        logic sleep_request;          // high = standby
        logic deselect_depth_select;  // low = dual, high = single deselect
        logic drive_strength_select;  // low = high drive, high = low drive
    } bsc_mode_t;

    localparam int BSC_MODE_W = $bits(bsc_mode_t);

    // values the pad pull devices give an open pin
    localparam bsc_mode_t BSC_MODE_RESET = '{
        burst_order_select_n: 1'b1,
        flow_through_select_n: 1'b1,
        sleep_request: 1'b0,
        deselect_depth_select: 1'b1,
        drive_strength_select: 1'b1
    };

    // kind of cycle last taken
    typedef enum logic [1:0] {
        BSC_OP_IDLE,
        BSC_OP_READ,
        BSC_OP_WRITE
    } bsc_op_t;

endpackage

//--- rtl/bsc_burst_if.sv
// link between the command decoder and the burst offset counter
// assumes both ends run on clk_sys
`timescale 1ns/1ps
interface bsc_burst_if;
    logic load;                         // take load_ofs as new start
    logic advance;                      // step to next offset
    logic linear;                       // linear order when high
    logic [1:0] load_ofs;               // low address bits to preset
    logic [1:0] ofs_now;                // offset held now
    logic [1:0] ofs_next;               // offset after one step

    modport ctl (output load, output advance, output linear, output load_ofs,
                 input ofs_now, input ofs_next);
    modport ctr (input load, input advance, input linear, input load_ofs,
                 output ofs_now, output ofs_next);
endinterface

//--- rtl/bsc_pin_sync.sv
// three-flop synchroniser for static, asynchronous mode pins
// assumes pins change rarely; a change is taken once stages two and three agree
`timescale 1ns/1ps
module bsc_pin_sync
#(
    parameter int W = 1,
    parameter logic [W-1:0] RESET_VAL = '0
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // pins and clean levels
    input wire logic [W-1:0] pin_raw,
    output logic [W-1:0] pin_clean
);
    import bsc_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] clean;
    } bsc_sync_t;

    bsc_sync_t st_q, st_d;
    logic [W-1:0] clean_nx;

    // ----------------------------------------------------------------
    // per-bit filter; stage one feeds stage two only
    // ----------------------------------------------------------------
    for (genvar i = 0; i < W; i++)
    begin : g_bit
        // agreement of the two settled stages guards against a half-caught edge
        assign clean_nx[i] = (st_q.s2[i] == st_q.s3[i]) ? st_q.s3[i] : st_q.clean[i];
    end

    // shift the stages and take the filtered level
    always_comb
    begin
        st_d = st_q;
        st_d.s1 = pin_raw;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        st_d.clean = clean_nx;
    end

    // stages reset to the open-pin defaults as well
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            st_q <= '{s1: RESET_VAL, s2: RESET_VAL, s3: RESET_VAL, clean: RESET_VAL};
        else
            st_q <= st_d;
    end

    assign pin_clean = st_q.clean;
endmodule

//--- rtl/bsc_burst_ctr.sv
// two-bit burst offset counter, linear or interleaved order
// assumes load and advance come from the decoder on clk_sys
`timescale 1ns/1ps
module bsc_burst_ctr
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // decoder side
    bsc_burst_if.ctr bif
);
    import bsc_pkg::*;

    typedef struct packed {
        logic [1:0] start;
        logic [1:0] step;
    } bsc_ctr_t;

    bsc_ctr_t st_q, st_d;
    logic [1:0] step_nx;

    // ----------------------------------------------------------------
    // next state: a load wins over an advance
    // ----------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        step_nx = st_q.step + BSC_STEP_ONE;          // wraps on the fifth clock RL2
        if (bif.load)
        begin
            st_d.start = bif.load_ofs;                  // RL18
            st_d.step = BSC_OFS_RESET;
        end
        else if (bif.advance)
            st_d.step = step_nx;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            st_q <= '{start: BSC_OFS_RESET, step: BSC_OFS_RESET};
        else
            st_q <= st_d;
    end

    // order applies to the sequence, not the stored state, so a held burst follows the pin
    assign bif.ofs_now = bif.linear ? st_q.start + st_q.step : st_q.start ^ st_q.step; // RL1
    assign bif.ofs_next = bif.linear ? st_q.start + step_nx : st_q.start ^ step_nx; // RL2

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_load_presets_start: assert property (bif.load |=> st_q.start == $past(bif.load_ofs)
        && bif.ofs_now == st_q.start) // RL18
        else $error("burst start not preset by load");
    a_step_wraps_fifth: assert property ((!bif.load && bif.advance)[*4] |=>
        st_q.step == $past(st_q.step, 4)) // RL2
        else $error("burst counter did not wrap after four steps");
    a_interleave_order: assert property (!bif.linear && !bif.load && bif.advance
        && st_q.step == BSC_OFS_RESET ##1 !bif.linear
        |-> bif.ofs_now == {st_q.start[1], !st_q.start[0]}) // RL1
        else $error("interleaved offset wrong");
endmodule

//--- rtl/bsc_core.sv
// control core of a synchronous burst static ram
// assumes an array with registered read: data valid the cycle after array_re
// assumes the pads provide pull devices and the tri-state data drivers
`timescale 1ns/1ps

// Notes on behaviour
// RL1: burst order pin low gives linear order, high gives interleaved order
// RL2: offset steps four addresses from start, back to start on fifth clock
// RL3: flow-through pin low bypasses output register, high or open uses pipeline
// RL4: sleep request high puts the part in standby, low or open is normal
// RL5: deselect depth pin low gives dual-cycle deselect, high or open single
// RL6: drive strength pin low gives high drive, high or open low drive
// RL7: open mode pins default to pipeline, single deselect, low drive, awake
// RL8: all-lane write low writes every lane whatever the other write inputs
// RL9: all-lane write and byte qualifier both high make a read on all lanes
// RL10: byte qualifier low writes exactly the lanes whose enable is low
// RL11: data lanes stay high impedance during every write cycle
// RL12: lanes c and d exist only in the wide configuration
// RL13: chip select high with controller strobe low is a deselect cycle
// RL14: selected with processor strobe low loads address and starts a read
// RL15: selected, processor strobe high, controller strobe low loads and starts
// RL16: both strobes high with advance low steps to the next burst address
// RL17: both strobes high with advance high holds the current burst address
// RL18: two lowest address bits preset the burst counter on every load
// RL19: output enable acts at once; high turns off, low only enables reads
// RL20: master may tie strobes for simple non-burst operation
// RL21: master may tie strobes and advance for simple burst operation
// RL22: reads with output enable high still advance the counter
// RL23: pipeline adds a clock of latency; single deselect turns off a stage early
// RL24: control, address and write inputs sampled on the rising clock edge
module bsc_core
#(
    parameter int LANES = bsc_pkg::BSC_LANES_WIDE,
    parameter int LANE_W = bsc_pkg::BSC_LANE_W,
    parameter int ADDR_W = bsc_pkg::BSC_ADDR_W
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // synchronous bus controls
    input wire logic chip_select_n,
    input wire logic processor_addr_strobe_n,
    input wire logic controller_addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic all_lane_write_n,
    input wire logic byte_write_qualifier_n,
    input wire logic [LANES-1:0] lane_write_enable_n,
    input wire logic [ADDR_W-1:0] addr_in,
    // asynchronous output enable, active low
    input wire logic output_enable_n,
    // static mode pins
    input wire logic burst_order_select_n,
    input wire logic flow_through_select_n,
    input wire logic sleep_request,
    input wire logic deselect_depth_select,
    input wire logic drive_strength_select,
    // data pins, split
    input wire logic [LANES*LANE_W-1:0] dq_in,
    output logic [LANES*LANE_W-1:0] dq_out,
    output logic [LANES-1:0] dq_oe_n,
    // storage array side
    output logic [ADDR_W-1:0] array_addr,
    output logic array_re,
    output logic [LANES-1:0] array_we,
    output logic [LANES*LANE_W-1:0] array_wr_data,
    input wire logic [LANES*LANE_W-1:0] array_rd_data,
    // status
    output logic sleep_active,
    output logic drive_high,
    output bsc_pkg::bsc_op_t last_op
);
    import bsc_pkg::*;

    localparam int DW = LANES * LANE_W;

    // ----------------------------------------------------------------
    // configuration check
    // ----------------------------------------------------------------
    // only the narrow and the wide arrangement have byte lanes wired out
    if (LANES != BSC_LANES_WIDE && LANES != BSC_LANES_NARROW)
    begin : g_bad_lanes
        $error("LANES must be 2 or 4"); // RL12
    end
    if (ADDR_W <= BSC_OFS_W)
    begin : g_bad_addr
        $error("ADDR_W must exceed the burst offset width");
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;     // address presented to the array
        logic re;                    // read issued this stage
        logic [LANES-1:0] we;        // lane write strobes
        logic [DW-1:0] wdata;        // write data captured with the command
        logic [DW-1:0] hold;         // output register stage of pipeline
        logic [DW-1:0] dout;         // data on the pins
        logic rd2;                   // read one stage past issue
        logic rd3;                   // read two stages past issue
        logic drive;                 // drivers on, before output enable
        bsc_op_t op;                 // last cycle kind taken
    } bsc_core_t;

    bsc_core_t st_q, st_d;
    bsc_mode_t mode_raw, mode;
    logic selected;
    logic load;
    logic advance;
    logic write_intent;
    logic cur_read;
    logic cur_write;
    logic [LANES-1:0] lane_mask;
    logic [ADDR_W-1:0] next_addr;

    bsc_burst_if bif ();

    // ----------------------------------------------------------------
    // mode pins and burst counter
    // ----------------------------------------------------------------
    // mode pins reset to the open-pin defaults and follow the pins once the synchroniser has settled
    assign mode_raw = '{
        burst_order_select_n: burst_order_select_n,
        flow_through_select_n: flow_through_select_n,
        sleep_request: sleep_request,
        deselect_depth_select: deselect_depth_select,
        drive_strength_select: drive_strength_select
    };

    bsc_pin_sync #(
        .W(BSC_MODE_W),
        .RESET_VAL(BSC_MODE_RESET) // RL7
    ) u_mode_sync (
        .clk_sys(clk_sys),
        .reset(reset),
        .pin_raw(mode_raw),
        .pin_clean(mode)
    );

    bsc_burst_ctr u_ctr (
        .clk_sys(clk_sys),
        .reset(reset),
        .bif(bif)
    );

    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    // byte-write truth table: global write overrides qualifier and lane enables
    always_comb
    begin
        if (!all_lane_write_n)
            lane_mask = '1;                           // RL8
        else if (!byte_write_qualifier_n)
            lane_mask = ~lane_write_enable_n;         // RL10
        else
            lane_mask = '0;                           // RL9
    end

    // a write with every lane enable high still counts as a write cycle
    assign write_intent = !all_lane_write_n || !byte_write_qualifier_n;

    // strobe priority; standby forces every cycle to a deselect
    always_comb
    begin
        selected = !chip_select_n;
        load = 1'b0;
        advance = 1'b0;
        cur_read = 1'b0;
        cur_write = 1'b0;
        if (mode.sleep_request)
        begin
            cur_read = 1'b0;                          // RL4
        end
        else if (selected && !processor_addr_strobe_n)
        begin
            load = 1'b1;                              // RL14
            cur_read = 1'b1;
        end
        else if (selected && !controller_addr_strobe_n)
        begin
            load = 1'b1;                              // RL15
            cur_write = write_intent;
            cur_read = !write_intent;
        end
        else if (!controller_addr_strobe_n)
        begin
            cur_read = 1'b0;                          // RL13
        end
        else
        begin
            // processor strobe ignored while deselected
            advance = !burst_advance_n;               // RL16 RL17
            cur_write = write_intent;
            cur_read = !write_intent;
        end
    end

    assign bif.load = load;
    assign bif.advance = advance;
    assign bif.linear = !mode.burst_order_select_n;   // RL1
    assign bif.load_ofs = addr_in[BSC_OFS_W-1:0];     // RL18

    // continue and suspend keep the loaded upper bits and swap in the counter offset
    always_comb
    begin
        if (load)
            next_addr = addr_in;
        else if (advance)
            next_addr = {st_q.addr[ADDR_W-1:BSC_OFS_W], bif.ofs_next}; // RL16
        else
            next_addr = {st_q.addr[ADDR_W-1:BSC_OFS_W], bif.ofs_now};  // RL17
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        // array command, taken on this rising edge
        st_d.addr = next_addr;                        // RL24
        st_d.re = cur_read;                           // RL22
        st_d.we = cur_write ? lane_mask : '0;         // RL10
        st_d.wdata = cur_write ? dq_in : st_q.wdata;
        st_d.rd2 = st_q.re;
        st_d.rd3 = st_q.rd2;
        // output register only used in pipeline mode
        st_d.hold = array_rd_data;
        if (!mode.flow_through_select_n)
            st_d.dout = array_rd_data;                // RL3
        else
            st_d.dout = st_q.hold;                    // RL23
        // drivers follow the read latency of the selected mode
        if (!mode.flow_through_select_n)
            st_d.drive = st_q.rd2 && (!mode.deselect_depth_select || st_q.re); // RL5
        else
            st_d.drive = st_q.rd3 && (!mode.deselect_depth_select || st_q.rd2); // RL23
        // a write or standby releases the bus at once
        if (cur_write || mode.sleep_request)
            st_d.drive = 1'b0;                        // RL11
        if (cur_write)
            st_d.op = BSC_OP_WRITE;
        else if (cur_read)
            st_d.op = BSC_OP_READ;
        else
            st_d.op = BSC_OP_IDLE;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            st_q <= '{addr: '0, re: 1'b0, we: '0, wdata: '0, hold: '0, dout: '0,
                      rd2: 1'b0, rd3: 1'b0, drive: 1'b0, op: BSC_OP_IDLE};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // output enable bypasses the clock so the bus can be freed mid-cycle
    assign dq_oe_n = {LANES{!st_q.drive || output_enable_n}}; // RL19
    assign dq_out = st_q.dout;
    assign array_addr = st_q.addr;
    assign array_re = st_q.re;
    assign array_we = st_q.we;
    assign array_wr_data = st_q.wdata;
    assign last_op = st_q.op;
    assign sleep_active = mode.sleep_request;         // RL4
    assign drive_high = !mode.drive_strength_select;  // RL6

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence s_proc_read;
        !mode.sleep_request && !chip_select_n && !processor_addr_strobe_n;
    endsequence

    sequence s_ctl_start;
        !mode.sleep_request && !chip_select_n && processor_addr_strobe_n
            && !controller_addr_strobe_n;
    endsequence

    sequence s_hold;
        !mode.sleep_request && controller_addr_strobe_n
            && (processor_addr_strobe_n || chip_select_n);
    endsequence

    a_proc_read_load: assert property (s_proc_read |=> array_re && array_we == '0
        && array_addr == $past(addr_in)) // RL14
        else $error("processor strobe did not start a read burst");
    a_global_write_all: assert property (s_ctl_start ##0 !all_lane_write_n
        |=> array_we == '1 && !array_re) // RL8
        else $error("global write did not write all lanes");
    a_lane_write_select: assert property (s_ctl_start ##0 all_lane_write_n
        ##0 !byte_write_qualifier_n |=> array_we == ~$past(lane_write_enable_n)) // RL10
        else $error("byte write lanes mismatch");
    a_deselect_no_access: assert property (chip_select_n && !controller_addr_strobe_n
        |=> !array_re && array_we == '0) // RL13
        else $error("deselect cycle touched the array");
    a_deselect_turn_off: assert property (chip_select_n && !controller_addr_strobe_n
        && (mode.deselect_depth_select || !mode.flow_through_select_n)
        |=> ##2 !st_q.drive) // RL5
        else $error("drivers still on after deselect");
    a_suspend_holds_addr: assert property (s_hold ##0 burst_advance_n
        |=> array_addr == $past(array_addr)) // RL17
        else $error("suspend moved the burst address");
    a_write_high_z: assert property (array_we != '0 |-> dq_oe_n == '1) // RL11
        else $error("drivers on during a write");
    a_flow_latency: assert property (!mode.flow_through_select_n && array_re
        |=> dq_out == $past(array_rd_data)) // RL3
        else $error("flow-through data late");
    a_pipe_latency: assert property (mode.flow_through_select_n && array_re ##1
        mode.flow_through_select_n |=> dq_out == $past(array_rd_data, 2)) // RL23
        else $error("pipeline data not one clock later");
    a_oe_gates_drive: assert property (output_enable_n |-> dq_oe_n == '1) // RL19
        else $error("output enable high left drivers on");
endmodule

//--- bench/bsc_array_model.sv
// storage array stand-in that sits behind the control core
// assumes one clock and a registered read, data out the cycle after array_re
`timescale 1ns/1ps
module bsc_array_model
(
    // clock
    input wire logic clk_sys,
    // array port
    input wire logic [21:0] array_addr,
    input wire logic array_re,
    input wire logic [3:0] array_we,
    input wire logic [35:0] array_wr_data,
    output logic [35:0] array_rd_data
);
    logic [35:0] mem [16];
    initial array_rd_data = '0;
    // --------
    // storage
    // --------
    // idle cycles show flipped data, so a late capture cannot pass by luck
    always @(posedge clk_sys)
    begin
        for (int i = 0; i < 4; i++)
            if (array_we[i]) mem[array_addr[3:0]][9*i+:9] <= array_wr_data[9*i+:9];
        array_rd_data <= array_re ? mem[array_addr[3:0]] : ~array_rd_data;
    end
endmodule

//--- bench/bsc_core_bench.sv
// self-checking bench for the burst sram control core
// assumes the default wide configuration and the array model beside it
`timescale 1ns/1ps
module bsc_core_bench;
    import bsc_pkg::*;
    // command codes: cs, proc strobe, ctl strobe, advance, all-lane write, qualifier
    localparam logic [5:0] CMD_RD_PS = 6'h0C;
    localparam logic [5:0] CMD_RD_CS = 6'h17;
    localparam logic [5:0] CMD_WR_ALL = 6'h15;
    localparam logic [5:0] CMD_WR_LANE = 6'h16;
    localparam logic [5:0] CMD_CONT = 6'h1B;
    localparam logic [5:0] CMD_HOLD = 6'h1F;
    localparam logic [5:0] CMD_DESEL = 6'h37;
    localparam logic [35:0] DAT0 = 36'h9_1234_5ABC;
    logic clk_sys, reset, chip_select_n, processor_addr_strobe_n, controller_addr_strobe_n;
    logic burst_advance_n, all_lane_write_n, byte_write_qualifier_n, output_enable_n;
    logic array_re, sleep_active, drive_high;
    logic [3:0] lane_write_enable_n, dq_oe_n, array_we;
    logic [21:0] addr_in, array_addr;
    logic [35:0] dq_in, dq_out, array_wr_data, array_rd_data;
    bsc_op_t last_op;
    bsc_mode_t m;
    int miscompares = 0;
    int tests_run = 0;
    int cyc = 0;
    bsc_core u_bsc_core (.clk_sys(clk_sys), .reset(reset), .chip_select_n(chip_select_n),
        .processor_addr_strobe_n(processor_addr_strobe_n),
        .controller_addr_strobe_n(controller_addr_strobe_n), .burst_advance_n(burst_advance_n),
        .all_lane_write_n(all_lane_write_n), .byte_write_qualifier_n(byte_write_qualifier_n),
        .lane_write_enable_n(lane_write_enable_n), .addr_in(addr_in),
        .output_enable_n(output_enable_n), .burst_order_select_n(m.burst_order_select_n),
        .flow_through_select_n(m.flow_through_select_n), .sleep_request(m.sleep_request),
        .deselect_depth_select(m.deselect_depth_select),
        .drive_strength_select(m.drive_strength_select), .dq_in(dq_in), .dq_out(dq_out),
        .dq_oe_n(dq_oe_n), .array_addr(array_addr), .array_re(array_re), .array_we(array_we),
        .array_wr_data(array_wr_data), .array_rd_data(array_rd_data),
        .sleep_active(sleep_active), .drive_high(drive_high), .last_op(last_op));
    bsc_array_model u_bsc_array_model (.clk_sys(clk_sys), .array_addr(array_addr),
        .array_re(array_re), .array_we(array_we), .array_wr_data(array_wr_data),
        .array_rd_data(array_rd_data));
    // --------
    // clock and watchdog
    // --------
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // the whole run needs well under a few hundred cycles
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            miscompares++;
            print_verdict();
        end
    end
    // --------
    // access tasks
    // --------
    // one bus cycle: inputs change at the falling edge, outputs read just after the rise
    task automatic op(input logic [5:0] c, input logic [3:0] le, input logic [21:0] a,
                      input logic [35:0] d);
        @(negedge clk_sys);
        {chip_select_n, processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n,
            all_lane_write_n, byte_write_qualifier_n} = c;
        lane_write_enable_n = le;
        addr_in = a;
        dq_in = d;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // --------
    // tests
    // --------
    initial
    begin
        {chip_select_n, processor_addr_strobe_n, controller_addr_strobe_n} = 3'h6;
        {burst_advance_n, all_lane_write_n, byte_write_qualifier_n} = 3'h7;
        {lane_write_enable_n, addr_in, dq_in, output_enable_n} = '0;
        m = BSC_MODE_RESET;
        reset = 1'b1;
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
        reset = 1'b0;
        chk(36'(dq_oe_n), 36'hF);
        chk(36'(drive_high), 36'h0);
        chk(36'(last_op), 36'(BSC_OP_IDLE));
        $display("reset test done");
        // lane enables are ignored under the all-lane write
        op(CMD_WR_ALL, 4'hF, 22'h000010, DAT0);
        chk(36'(array_we), 36'hF);
        chk(array_wr_data, DAT0);
        chk(36'(dq_oe_n), 36'hF);
        op(CMD_WR_LANE, 4'hA, 22'h000011, ~DAT0);
        chk(36'(array_we), 36'h5);
        op(CMD_WR_LANE, 4'hF, 22'h000012, ~DAT0);
        chk(36'(array_we), 36'h0);
        chk(36'(last_op), 36'(BSC_OP_WRITE));
        $display("write test done");
        // write inputs held low must not turn the processor-strobe load into a write
        op(CMD_RD_PS, 4'h0, 22'h000010, '0);
        chk(36'(last_op), 36'(BSC_OP_READ));
        chk(36'(array_addr), 36'h10);
        op(CMD_HOLD, 4'hF, 22'h3FFFFF, '0);
        chk(36'(array_addr), 36'h10);
        repeat (2) op(CMD_HOLD, 4'hF, 22'h3FFFFF, '0);
        chk(dq_out, DAT0);
        chk(36'(dq_oe_n), 36'h0);
        output_enable_n = 1'b1;
        #1;
        chk(36'(dq_oe_n), 36'hF);
        $display("read test done");
        // interleaved burst, drivers held off to prove dummy reads still count
        op(CMD_RD_PS, 4'hF, 22'h00002E, '0);
        for (int i = 1; i <= 4; i++)
        begin
            op(CMD_CONT, 4'hF, 22'h3FFFFF, '0);
            chk(36'(array_addr), 36'({20'h0000B, 2'(2 ^ (i % 4))}));
        end
        output_enable_n = 1'b0;
        $display("interleaved test done");
        @(negedge clk_sys);
        m.burst_order_select_n = 1'b0;
        m.drive_strength_select = 1'b0;
        m.flow_through_select_n = 1'b0;
        m.deselect_depth_select = 1'b0;
        repeat (5) op(CMD_DESEL, 4'hF, 22'h3FFFFF, '0);
        chk(36'(drive_high), 36'h1);
        chk(36'(last_op), 36'(BSC_OP_IDLE));
        chk(36'(dq_oe_n), 36'hF);
        op(CMD_RD_CS, 4'hF, 22'h00002D, '0);
        chk(36'(last_op), 36'(BSC_OP_READ));
        for (int i = 1; i <= 4; i++)
        begin
            op(CMD_CONT, 4'hF, 22'h3FFFFF, '0);
            chk(36'(array_addr), 36'({20'h0000B, 2'(1 + i)}));
        end
        op(CMD_RD_PS, 4'hF, 22'h000010, '0);
        repeat (2) op(CMD_HOLD, 4'hF, 22'h3FFFFF, '0);
        chk(dq_out, DAT0);
        chk(36'(dq_oe_n), 36'h0);
        repeat (2) op(CMD_DESEL, 4'hF, 22'h3FFFFF, '0);
        chk(36'(dq_oe_n), 36'h0);
        $display("linear test done");
        @(negedge clk_sys);
        m.sleep_request = 1'b1;
        repeat (5) op(CMD_HOLD, 4'hF, 22'h3FFFFF, '0);
        chk(36'(sleep_active), 36'h1);
        op(CMD_RD_PS, 4'hF, 22'h000010, '0);
        chk(36'(last_op), 36'(BSC_OP_IDLE));
        chk(36'(array_re), 36'h0);
        $display("sleep test done");
        print_verdict();
    end
endmodule
